/* File: rtl/pcs_atan2.sv */
// Iterative four-quadrant arctangent, angle with 2^16 per turn.
// Assumes start pulses only while idle; result held until next done.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_atan2 #(
   parameter int IN_W = 24
) (
   // Clock and control
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // Vector in
   input wire logic start,
   input wire logic signed [IN_W-1:0] x_in,
   input wire logic signed [IN_W-1:0] y_in,
   // Angle out
   output logic done,
   output logic signed [`PCS_ANG_W-1:0] ang
);
   function automatic logic [`PCS_ANG_W-1:0] atan_step(input logic [3:0] i);
      unique case (i)
         4'h0: atan_step = 16'h2000;
         4'h1: atan_step = 16'h12E4;
         4'h2: atan_step = 16'h09FB;
         4'h3: atan_step = 16'h0511;
         4'h4: atan_step = 16'h028B;
         4'h5: atan_step = 16'h0146;
         4'h6: atan_step = 16'h00A3;
         4'h7: atan_step = 16'h0051;
         4'h8: atan_step = 16'h0029;
         4'h9: atan_step = 16'h0014;
         4'hA: atan_step = 16'h000A;
         4'hB: atan_step = 16'h0005;
         4'hC: atan_step = 16'h0003;
         default: atan_step = 16'h0001;
      endcase
   endfunction

   pcs_pkg::pcs_at_st_t st_ff;
   logic signed [IN_W+1:0] x_ff, y_ff;
   logic signed [`PCS_ANG_W-1:0] z_ff;
   logic [3:0] it_ff;
   // One micro-rotation toward the x axis
   wire neg_y = y_ff[IN_W+1];
   wire signed [IN_W+1:0] xs = x_ff >>> it_ff;
   wire signed [IN_W+1:0] ys = y_ff >>> it_ff;
   wire signed [`PCS_ANG_W-1:0] stp = `PCS_ANG_W'(atan_step(it_ff));
   wire last = (it_ff == 4'(`PCS_CORDIC_N - 1));
   // Left half plane is folded by a half turn first
   wire flip = x_in[IN_W-1];

   // Iteration state, frozen while ce is low
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= pcs_pkg::PCS_AT_IDLE;
         x_ff <= '0;
         y_ff <= '0;
         z_ff <= '0;
         it_ff <= 4'h0;
         done <= 1'b0;
         ang <= '0;
      end else if (ce) begin
         done <= 1'b0;
         unique case (st_ff)
            pcs_pkg::PCS_AT_IDLE: begin
               if (start) begin
                  x_ff <= flip ? -(IN_W+2)'(x_in) : (IN_W+2)'(x_in);
                  y_ff <= flip ? -(IN_W+2)'(y_in) : (IN_W+2)'(y_in);
                  z_ff <= flip ? 16'sh8000 : 16'sh0000;
                  it_ff <= 4'h0;
                  st_ff <= pcs_pkg::PCS_AT_RUN;
               end
            end
            pcs_pkg::PCS_AT_RUN: begin
               x_ff <= neg_y ? x_ff - ys : x_ff + ys;
               y_ff <= neg_y ? y_ff + xs : y_ff - xs;
               z_ff <= neg_y ? z_ff - stp : z_ff + stp;
               it_ff <= it_ff + 4'h1;
               if (last) begin
                  done <= 1'b1;
                  ang <= neg_y ? z_ff - stp : z_ff + stp;
                  st_ff <= pcs_pkg::PCS_AT_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: rtl/pcs_defs.svh */
// Constants for the peer clock phase sync block.
// Assumes a 100 MHz clk and one sample tick per 1/64 power cycle.
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// Clock rate
`define PCS_CLK_MHZ 100
// Exchange broken longer than this forces a start-up set
`define PCS_BREAK_MS 66
`define PCS_BREAK_CYC (`PCS_BREAK_MS * `PCS_CLK_MHZ * 1000)
// Stamp format: 8-bit sample count, 64 counts per cycle
`define PCS_TS_W 8
`define PCS_TS_WRAP 256
`define PCS_TS_HALF_WRAP 128
// Half a cycle in half-counts (theta is kept doubled)
`define PCS_HALF_CYC_HC 64
// Half-count to angle shift: one count is pi/32, cycle is 2^16
`define PCS_HC_TO_ANG 9
// Working widths
`define PCS_DIFF_W 12
`define PCS_PH_W 24
`define PCS_ANG_W 16
// Gain fraction bits
`define PCS_GAIN_Q 16
// Repeat period and loop time constants, microseconds
`define PCS_T_REPEAT_US 16667
`define PCS_T_PHASE_US 500000
`define PCS_T_FREQ_US 100000
// Cycles per loop update on a 9600 baud channel
`define PCS_SLOW_DIV 3
// Arctangent iterations
`define PCS_CORDIC_N 14

`endif

/* File: rtl/pcs_phase_sync.sv */
// Phase detection and PI loop filter for the sample clock.
// Assumes a framer that marks first and complete stamp messages.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_phase_sync #(
   parameter int PEERS = 3,
   parameter int MSGS_PER_CYCLE = 4,
   parameter int BREAK_CYC = `PCS_BREAK_CYC,
   parameter longint T_REPEAT_US = `PCS_T_REPEAT_US,
   parameter longint T_PHASE_US = `PCS_T_PHASE_US,
   parameter longint T_FREQ_US = `PCS_T_FREQ_US,
   parameter int PEER_W = (PEERS > 1) ? $clog2(PEERS) : 1
) (
   // Clock and control
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // Timing
   input wire logic sample_tick,
   input wire logic cycle_tick,
   input wire logic slow_link,
   input wire logic [2:0] n_terms,
   // Transmit side
   input wire logic tx_req,
   input wire logic [PEER_W-1:0] tx_peer,
   input wire logic [1:0] tx_slot,
   // Receive side
   input wire logic rx_first,
   input wire logic rx_done,
   input wire logic [PEER_W-1:0] rx_peer,
   input wire logic rx_startup,
   input wire logic [`PCS_TS_W-1:0] rx_t0,
   input wire logic [`PCS_TS_W-1:0] rx_t1,
   input wire logic [`PCS_TS_W-1:0] rx_t2,
   // Current and frequency measurements
   input wire logic cur_strobe,
   input wire logic cur_large,
   input wire logic signed [`PCS_PH_W-1:0] prod_re,
   input wire logic signed [`PCS_PH_W-1:0] prod_im,
   input wire logic freq_ok,
   input wire logic signed [`PCS_PH_W-1:0] freq_dev,
   // Outgoing stamps
   output logic tx_out_vld,
   output logic tx_startup,
   output logic [2:0] tx_mask,
   output logic [`PCS_TS_W-1:0] tx_st0,
   output logic [`PCS_TS_W-1:0] tx_st1,
   output logic [`PCS_TS_W-1:0] tx_st2,
   // Status
   output logic [`PCS_TS_W-1:0] stamp_cnt,
   output logic [`PCS_DIFF_W-1:0] round_trip,
   output logic src_current,
   // Loop filter
   output logic loop_upd,
   output logic signed [`PCS_PH_W-1:0] phase_in,
   output logic signed [31:0] clk_adj
);
   localparam int DW = `PCS_DIFF_W;
   localparam int PW = `PCS_PH_W;
   localparam int TW = `PCS_TS_W;
   localparam int BW = $clog2(BREAK_CYC + 1);
   localparam int AW = 48;
   // Gains in Q16 per second: Trep/Tph^2, 2/Tph, Trep/Tf
   localparam longint US = 1000000;
   localparam longint GQ = 1 << `PCS_GAIN_Q;
   localparam longint INTEG_L = T_REPEAT_US * US * GQ / (T_PHASE_US * T_PHASE_US);
   localparam longint PROP_L = 2 * US * GQ / T_PHASE_US;
   localparam longint FREQ_L = T_REPEAT_US * GQ / T_FREQ_US;
   localparam logic signed [31:0] INTEGRAL_GAIN = 32'(INTEG_L);
   localparam logic signed [31:0] PROPORTIONAL_GAIN = 32'(PROP_L);
   localparam logic signed [31:0] FREQUENCY_GAIN = 32'(FREQ_L);

   // Unsigned stamp widened to the signed difference width
   function automatic logic signed [DW-1:0] wid(input logic [TW-1:0] t);
      wid = DW'({1'b0, t});
   endfunction

   // Per-peer memories
   logic [TW-1:0] keep0_ff [PEERS];
   logic [TW-1:0] keep1_ff [PEERS];
   logic [TW-1:0] rxts_ff [PEERS];
   logic [TW-1:0] snap0_ff [PEERS];
   logic [TW-1:0] snap1_ff [PEERS];
   logic [TW-1:0] snap2_ff [PEERS];
   logic [PEERS-1:0] snap_su_ff;
   logic [BW-1:0] idle_ff [PEERS];
   logic [PEERS-1:0] live_ff;
   logic [PEERS-1:0] thv_ff;
   logic signed [DW-1:0] theta_ff [PEERS];
   // Shared state
   logic [TW-1:0] cnt_ff;
   logic [1:0] div_ff;
   logic signed [AW-1:0] acc_ff;
   logic signed [PW-1:0] cur_ph_ff;
   logic cur_ok_ff;

   // Sample counter, wraps naturally at 256
   always_ff @(posedge clk) begin
      if (srst)
         cnt_ff <= '0;
      else if (ce && sample_tick)
         cnt_ff <= cnt_ff + 8'h01;
   end
   assign stamp_cnt = cnt_ff;

   // Receive stamp: this cycle's count when first and done coincide
   wire [TW-1:0] ti = rx_first ? cnt_ff : rxts_ff[rx_peer];
   // Ping-pong arithmetic on the three carried stamps plus arrival
   wire signed [DW-1:0] dif_a = wid(rx_t1) - wid(rx_t0);
   wire signed [DW-1:0] dif_b = wid(ti) - wid(rx_t2);
   wire wrap_far = rx_t1 > rx_t2;
   wire wrap_loc = rx_t0 > ti;
   wire signed [DW-1:0] corr = (wrap_far ? -DW'(`PCS_TS_WRAP) : DW'(0))
      + (wrap_loc ? DW'(`PCS_TS_WRAP) : DW'(0));
   // Theta is kept doubled so 128 becomes 256 and no bit is lost
   wire signed [DW-1:0] rt_w = dif_a + dif_b + corr;
   wire signed [DW-1:0] th2_w = dif_a - dif_b + corr;
   wire full_rx = rx_done && !rx_startup;

   // Arrival stamp of each sequence's first message
   always_ff @(posedge clk) begin
      if (ce && rx_first)
         rxts_ff[rx_peer] <= cnt_ff;
   end

   // Stamps handed on to the next outgoing message
   always_ff @(posedge clk) begin
      if (ce && rx_done) begin
         keep0_ff[rx_peer] <= rx_t2;
         keep1_ff[rx_peer] <= ti;
      end
   end

   // Last round trip seen, for status only
   always_ff @(posedge clk) begin
      if (srst)
         round_trip <= '0;
      else if (ce && full_rx)
         round_trip <= rt_w;
   end

   // Per-peer liveness and offset; arrival beats timeout
   genvar gp;
   generate
      for (gp = 0; gp < PEERS; gp++) begin : g_peer
         wire hit = rx_done && (rx_peer == PEER_W'(gp));
         wire stale = (idle_ff[gp] >= BW'(BREAK_CYC));
         always_ff @(posedge clk) begin
            if (srst) begin
               idle_ff[gp] <= '0;
               live_ff[gp] <= 1'b0;
               thv_ff[gp] <= 1'b0;
               theta_ff[gp] <= '0;
            end else if (ce) begin
               if (hit)
                  idle_ff[gp] <= '0;
               else if (!stale)
                  idle_ff[gp] <= idle_ff[gp] + BW'(1);
               if (hit)
                  live_ff[gp] <= 1'b1;
               else if (stale)
                  live_ff[gp] <= 1'b0;
               if (hit && rx_startup)
                  thv_ff[gp] <= 1'b0;
               else if (hit)
                  thv_ff[gp] <= 1'b1;
               else if (stale)
                  thv_ff[gp] <= 1'b0;
               if (hit && !rx_startup)
                  theta_ff[gp] <= th2_w;
            end
         end
      end
   endgenerate

   // Transmit: slot 0 takes a fresh set, later slots reuse it
   wire tx_new = tx_req && (tx_slot == 2'd0);
   wire su_w = tx_new ? !live_ff[tx_peer] : snap_su_ff[tx_peer];
   wire [TW-1:0] s0_w = tx_new ? keep0_ff[tx_peer] : snap0_ff[tx_peer];
   wire [TW-1:0] s1_w = tx_new ? keep1_ff[tx_peer] : snap1_ff[tx_peer];
   wire [TW-1:0] s2_w = tx_new ? cnt_ff : snap2_ff[tx_peer];
   // One message per cycle carries all three; four spread over slots 0-2
   wire [2:0] slot_oh = (tx_slot == 2'd3) ? 3'b000 : 3'(3'b001 << tx_slot);
   wire [2:0] base_m = (MSGS_PER_CYCLE == 1) ? 3'b111 : slot_oh;
   wire [2:0] mask_w = su_w ? (base_m & 3'b100) : base_m;

   // Snapshot kept for the rest of the sequence
   always_ff @(posedge clk) begin
      if (ce && tx_new) begin
         snap0_ff[tx_peer] <= s0_w;
         snap1_ff[tx_peer] <= s1_w;
         snap2_ff[tx_peer] <= s2_w;
      end
   end

   // Start-up marks, set at reset so the first send is a start-up set
   always_ff @(posedge clk) begin
      if (srst)
         snap_su_ff <= '1;
      else if (ce && tx_new)
         snap_su_ff[tx_peer] <= su_w;
   end

   // Outgoing stamp registers
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_out_vld <= 1'b0;
         tx_startup <= 1'b0;
         tx_mask <= 3'b000;
         tx_st0 <= '0;
         tx_st1 <= '0;
         tx_st2 <= '0;
      end else if (ce) begin
         tx_out_vld <= tx_req;
         if (tx_req) begin
            tx_startup <= su_w;
            tx_mask <= mask_w;
            tx_st0 <= su_w ? 8'h00 : s0_w;
            tx_st1 <= su_w ? 8'h00 : s1_w;
            tx_st2 <= s2_w;
         end
      end
   end

   // Net stamp deviation: sum over peers with a valid offset, divide by their count plus self
   logic signed [DW+2:0] th_sum;
   logic [3:0] n_part;
   always_comb begin
      th_sum = '0;
      n_part = 4'h1;
      for (int p = 0; p < PEERS; p++) begin
         if (thv_ff[p]) begin
            th_sum = th_sum + (DW+3)'(theta_ff[p]);
            n_part = n_part + 4'h1;
         end
      end
   end
   wire signed [DW+2:0] th_net = th_sum / $signed({1'b0, n_part});
   wire [DW+2:0] th_abs = th_net[DW+2] ? -th_net : th_net;
   wire stamp_in_range = th_abs < (DW+3)'(`PCS_HALF_CYC_HC);
   // Doubled counts times 2^9 is the angle at pi/32 per count
   wire signed [PW-1:0] stamp_ph = PW'(th_net) <<< `PCS_HC_TO_ANG;

   // Current based deviation, two terminals only
   wire two_term = (n_terms == 3'd2);
   wire at_done;
   wire signed [`PCS_ANG_W-1:0] at_ang;
   pcs_atan2 #(
      .IN_W(PW)
   ) u_atan (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .start(cur_strobe && two_term),
      .x_in(-prod_re),
      .y_in(-prod_im),
      .done(at_done),
      .ang(at_ang)
   );

   // Latest current phase and whether currents backed it
   always_ff @(posedge clk) begin
      if (srst) begin
         cur_ph_ff <= '0;
         cur_ok_ff <= 1'b0;
      end else if (ce) begin
         if (at_done) begin
            cur_ph_ff <= PW'(at_ang >>> 1);
            cur_ok_ff <= cur_large;
         end
         if (!two_term)
            cur_ok_ff <= 1'b0;
      end
   end

   // Source choice and frequency input
   wire cur_valid = cur_ok_ff && cur_large && two_term && stamp_in_range;
   wire signed [PW-1:0] ph_sel = cur_valid ? cur_ph_ff : stamp_ph;
   wire signed [PW-1:0] fr_sel = freq_ok ? freq_dev : PW'(0);

   // Update cadence: each cycle fast, every third cycle slow
   wire div_end = (div_ff == 2'(`PCS_SLOW_DIV - 1));
   wire upd = cycle_tick && (!slow_link || div_end);
   always_ff @(posedge clk) begin
      if (srst)
         div_ff <= 2'd0;
      else if (ce && cycle_tick)
         div_ff <= (div_end || !slow_link) ? 2'd0 : div_ff + 2'd1;
   end

   // PI with one accumulator; a second one could drift to saturation
   wire signed [AW-1:0] igain_t = AW'(ph_sel) * AW'(INTEGRAL_GAIN);
   wire signed [AW-1:0] fgain_t = AW'(fr_sel) * AW'(FREQUENCY_GAIN);
   wire signed [AW-1:0] pgain_t = AW'(ph_sel) * AW'(PROPORTIONAL_GAIN);
   wire signed [AW-1:0] acc_nxt = acc_ff + igain_t + fgain_t;
   wire signed [AW-1:0] out_w = (acc_nxt + pgain_t) >>> `PCS_GAIN_Q;

   // Filter state and outputs
   always_ff @(posedge clk) begin
      if (srst) begin
         acc_ff <= '0;
         loop_upd <= 1'b0;
         phase_in <= '0;
         clk_adj <= '0;
         src_current <= 1'b0;
      end else if (ce) begin
         loop_upd <= upd;
         if (upd) begin
            acc_ff <= acc_nxt;
            phase_in <= ph_sel;
            clk_adj <= 32'(out_w);
            src_current <= cur_valid;
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/pcs_pkg.sv */
// Types shared by the peer clock phase sync block.
// Used through pcs_pkg:: names only.
package pcs_pkg;
   typedef enum logic [0:0] {
      PCS_AT_IDLE,
      PCS_AT_RUN
   } pcs_at_st_t;
   typedef enum logic [0:0] {
      PCS_SRC_STAMP,
      PCS_SRC_CURRENT
   } pcs_src_t;
endpackage

/* File: verif/pcs_peer_model.sv */
// Peer unit model: stamps our messages on arrival and answers later.
// Assumes its sample counter runs at our rate with an offset from the bench.
`timescale 1ns/1ps
`default_nettype none
module pcs_peer_model (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bench commands
   input wire logic [7:0] ofs,
   input wire logic [7:0] dly,
   input wire logic send_su,
   // Messages from the block
   input wire logic tx_req,
   input wire logic [1:0] tx_slot,
   input wire logic tx_out_vld,
   input wire logic [2:0] tx_mask,
   input wire logic [7:0] tx_st2,
   input wire logic [7:0] stamp_cnt,
   // Answers to the block
   output logic rx_first,
   output logic rx_done,
   output logic rx_startup,
   output logic [7:0] rx_t0,
   output logic [7:0] rx_t1,
   output logic [7:0] rx_t2
);
   logic [1:0] slot_ff;
   logic [7:0] arr_ff, st_ff, snd_ff, wt_ff;
   wire [7:0] own_cnt = stamp_cnt + ofs;

   // Slot of the message in flight
   always @(posedge clk) begin
      if (tx_req) begin
         slot_ff <= tx_slot;
      end
   end
   // Answer dly cycles after our stamp; idle stamp lines change every cycle (t0, t1 toggle, t2 steps) so stale data never passes
   always @(negedge clk) begin
      rx_first <= 1'b0;
      rx_done <= 1'b0;
      rx_startup <= 1'b0;
      rx_t0 <= ~rx_t0;
      rx_t1 <= ~rx_t1;
      rx_t2 <= rx_t2 + 8'h35;
      if (srst) begin
         wt_ff <= 8'h00;
         {rx_t0, rx_t1, rx_t2} <= 24'h5A3C96; // Seed for the idle toggling
      end else begin
         if (tx_out_vld && slot_ff == 2'h0) begin
            arr_ff <= own_cnt;
         end
         if (tx_out_vld && tx_mask[2]) begin
            st_ff <= tx_st2;
            wt_ff <= dly;
         end else if (wt_ff != 8'h00) begin
            wt_ff <= wt_ff - 8'h01;
         end
         if (wt_ff == 8'h02) begin
            rx_first <= 1'b1;
            snd_ff <= own_cnt;
         end
         if (wt_ff == 8'h01) begin
            rx_done <= 1'b1;
            rx_startup <= send_su;
            rx_t2 <= snd_ff;
            if (!send_su) begin
               rx_t0 <= st_ff;
               rx_t1 <= arr_ff;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: verif/pcs_phase_sync_asserts.sv */
// Checker for the peer clock phase sync block: counter, stamps, updates.
// Assumes one clk domain, srst synchronous active high, bound to the top.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_phase_sync_asserts #(
   parameter int MSGS_PER_CYCLE = 4
) (
   // Clock and control
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   // Inputs watched
   input wire logic sample_tick,
   input wire logic cycle_tick,
   input wire logic slow_link,
   input wire logic [2:0] n_terms,
   input wire logic tx_req,
   input wire logic [1:0] tx_slot,
   input wire logic cur_large,
   input wire logic rx_done,
   input wire logic rx_startup,
   // Outputs watched
   input wire logic tx_out_vld,
   input wire logic tx_startup,
   input wire logic [2:0] tx_mask,
   input wire logic [`PCS_TS_W-1:0] tx_st0,
   input wire logic [`PCS_TS_W-1:0] tx_st1,
   input wire logic [`PCS_TS_W-1:0] tx_st2,
   input wire logic [`PCS_TS_W-1:0] stamp_cnt,
   input wire logic [`PCS_DIFF_W-1:0] round_trip,
   input wire logic src_current,
   input wire logic loop_upd
);
   // Slot mask a normal set should carry
   wire [2:0] exp_mask;
   assign exp_mask = (MSGS_PER_CYCLE == 1) ? 3'h7 : (tx_slot == 2'h3) ? 3'h0 : 3'h1 << tx_slot;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Accepted requests and fast-link cycle ticks
   sequence s_tx;
      ce && tx_req;
   endsequence
   sequence s_upd;
      ce && cycle_tick && !slow_link;
   endsequence

   a_cnt_step: assert property (ce && sample_tick |=> stamp_cnt == $past(stamp_cnt) + 8'h01)
      else $error("stamp counter did not step");
   a_cnt_hold: assert property (!(ce && sample_tick) |=> $stable(stamp_cnt))
      else $error("stamp counter moved without a tick");
   a_tx_pulse: assert property (ce |=> tx_out_vld == $past(tx_req))
      else $error("transmit valid not one cycle after request");
   a_tx_time: assert property (s_tx ##0 tx_slot == 2'h0 |=> tx_st2 == $past(stamp_cnt))
      else $error("transmit stamp not taken at first message");
   a_slot_mask: assert property (s_tx |=> tx_startup || tx_mask == $past(exp_mask))
      else $error("stamp mask wrong for slot");
   a_startup_set: assert property (s_tx ##1 tx_startup |-> tx_mask[1:0] == 2'h0 && tx_st0 == 8'h00 && tx_st1 == 8'h00)
      else $error("start-up set carries more than transmit time");
   a_startup_rx: assert property (ce && rx_done && rx_startup |=> $stable(round_trip))
      else $error("round trip changed on a start-up set");
   a_upd_fast: assert property (s_upd |=> loop_upd)
      else $error("no loop update after cycle tick");
   a_upd_none: assert property (ce && !cycle_tick |=> !loop_upd)
      else $error("loop update without cycle tick");
   a_src_terms: assert property ($past(ce) && loop_upd && $past(n_terms) != 3'h2 |-> !src_current)
      else $error("current source used without two terminals");
   a_src_large: assert property ($past(ce) && loop_upd && !$past(cur_large) |-> !src_current)
      else $error("current source used with small currents");
endmodule
bind pcs_phase_sync pcs_phase_sync_asserts #(.MSGS_PER_CYCLE(MSGS_PER_CYCLE)) pcs_phase_sync_asserts_i (
   .clk, .srst, .ce, .sample_tick, .cycle_tick, .slow_link, .n_terms, .tx_req, .tx_slot,
   .cur_large, .rx_done, .rx_startup, .tx_out_vld, .tx_startup, .tx_mask, .tx_st0,
   .tx_st1, .tx_st2, .stamp_cnt, .round_trip, .src_current, .loop_upd);
`default_nettype wire

/* File: verif/pcs_phase_sync_tb.sv */
// Bench for the peer clock phase sync block against an integer model.
// Assumes the peer model on the receive side; stimulus moves at falling clk.
`timescale 1ns/1ps
`default_nettype none
module pcs_phase_sync_tb;
   logic clk = 1'b0, srst = 1'b1, ce = 1'b1, sample_tick = 1'b0, cycle_tick = 1'b0;
   logic slow_link = 1'b0, tx_req = 1'b0, cur_strobe = 1'b0, cur_large = 1'b0;
   logic freq_ok = 1'b0, send_su = 1'b0, tx_peer = 1'b0, rx_peer = 1'b0;
   logic [2:0] n_terms = 3'h2;
   logic [1:0] tx_slot = 2'h0;
   logic [7:0] ofs = 8'h02, dly = 8'h03;
   logic signed [23:0] prod_re = 24'h000000, prod_im = 24'h000000, freq_dev = 24'h000000;
   logic rx_first, rx_done, rx_startup, tx_out_vld, tx_startup, src_current, loop_upd;
   logic [7:0] rx_t0, rx_t1, rx_t2, tx_st0, tx_st1, tx_st2, stamp_cnt;
   logic [2:0] tx_mask;
   logic [11:0] round_trip;
   logic signed [23:0] phase_in;
   logic signed [31:0] clk_adj;
   int mcnt = 0, c_prev = 0, ti = 0, t_tx = 0, sv0 = 0, sv1 = 0, rt = 0, th2 = 0, pv = 0;
   int err_count = 0, num_checks = 0, cycles = 0, seed = 32'h37B1, rnd_ce = 0, i, n;
   int fr = 0, acc_ok = 1;
   longint acc = 0;
   // Filter gains in Q16 from the repeat period and the loop time constants
   localparam longint T_REP = 16667, T_PH = 500000, T_FR = 100000, GQ = 65536;
   localparam longint GAIN_I = T_REP * 1000000 * GQ / (T_PH * T_PH);
   localparam longint GAIN_P = 2 * 1000000 * GQ / T_PH;
   localparam longint GAIN_F = T_REP * GQ / T_FR;

   pcs_phase_sync #(.PEERS(2), .MSGS_PER_CYCLE(4), .BREAK_CYC(200)) pcs_phase_sync_i (
      .clk, .srst, .ce, .sample_tick, .cycle_tick, .slow_link, .n_terms, .tx_req, .tx_peer,
      .tx_slot, .rx_first, .rx_done, .rx_peer, .rx_startup, .rx_t0, .rx_t1, .rx_t2,
      .cur_strobe, .cur_large, .prod_re, .prod_im, .freq_ok, .freq_dev, .tx_out_vld,
      .tx_startup, .tx_mask, .tx_st0, .tx_st1, .tx_st2, .stamp_cnt, .round_trip,
      .src_current, .loop_upd, .phase_in, .clk_adj);
   pcs_peer_model pcs_peer_model_i (.clk, .srst, .ofs, .dly, .send_su, .tx_req, .tx_slot,
      .tx_out_vld, .tx_mask, .tx_st2, .stamp_cnt, .rx_first, .rx_done, .rx_startup,
      .rx_t0, .rx_t1, .rx_t2);

   // 100 MHz clock and a hang limit well above the run length
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic note(input string s);
      $display("test %s done", s);
   endtask
   // One falling edge: counter compare, arrival stamp, random inputs
   task automatic cyc();
      @(negedge clk);
      chk(stamp_cnt, mcnt[7:0]);
      if (rx_first) ti = c_prev;
      c_prev = mcnt;
      ce = !rnd_ce || ($random(seed) % 8 != 0);
      sample_tick = 1'($random(seed));
      freq_ok = 1'($random(seed));
      freq_dev = 24'($random(seed));
      if (ce && sample_tick) mcnt = (mcnt + 1) % 256;
   endtask
   // Slots 0..3 back to back
   task automatic send(input logic su);
      int k;
      for (k = 0; k < 4; k++) begin
         tx_slot = 2'(k);
         tx_req = 1'b1;
         if (k == 0) t_tx = c_prev;
         cyc();
         chk(tx_out_vld, 1);
         chk(tx_startup, su);
         chk(tx_mask, su ? (k == 2 ? 4 : 0) : (k < 3 ? 1 << k : 0));
         if (k == 2) chk(tx_st2, t_tx[7:0]);
         if (k < 2) chk(k ? tx_st1 : tx_st0, su ? 0 : (k ? sv1 : sv0));
      end
      tx_req = 1'b0;
   endtask
   // Peer answer and round trip against the model
   task automatic await_reply();
      for (n = 0; n < 300 && !rx_done; n++) cyc();
      chk(rx_done, 1);
      if (rx_startup) begin
         pv = 0;
         chk(round_trip, rt[11:0]);
      end else begin
         rt = int'(rx_t1) - int'(rx_t0) + ti - int'(rx_t2);
         th2 = int'(rx_t1) - int'(rx_t0) - ti + int'(rx_t2);
         if (rx_t1 > rx_t2) begin
            rt -= 256;
            th2 -= 256;
         end
         if (rx_t0 > ti) begin
            rt += 256;
            th2 += 256;
         end
         pv = 1;
         chk(round_trip, rt[11:0]);
      end
      sv0 = rx_t2;
      sv1 = ti;
   endtask
   // Loop update; one peer plus the local unit share the average
   task automatic upd(input logic cur);
      int net;
      net = pv ? th2 / 2 : 0;
      fr = freq_ok ? freq_dev : 0;
      cycle_tick = 1'b1;
      cyc();
      cycle_tick = 1'b0;
      chk(loop_upd, 1);
      cur = cur && cur_large && n_terms == 3'h2 && net > -64 && net < 64;
      chk(src_current, cur);
      if (cur) chk({31'h0, phase_in >= 24'sd8160 && phase_in <= 24'sd8224}, 1);
      else chk({8'h00, phase_in}, {8'h00, 24'(net * 512)});
      // One shared integrator takes both the phase and the frequency term
      acc += longint'(net * 512) * GAIN_I + longint'(fr) * GAIN_F;
      if (acc_ok) chk(clk_adj, 32'((acc + longint'(net * 512) * GAIN_P) >>> 16));
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(negedge clk);
      srst = 1'b0;
      rnd_ce = 1;
      repeat (600) cyc();
      rnd_ce = 0;
      cyc();
      note("counter");
      send(1'b1);
      await_reply();
      upd(1'b0);
      send(1'b0);
      await_reply();
      upd(1'b0);
      note("exchange");
      // Arctangent phase is not exact, so the filter model stops here
      acc_ok = 0;
      // Current source per terminal count; quarter turn halves to 8192
      for (i = 2; i < 5; i++) begin
         n_terms = 3'(i);
         cur_large = 1'b1;
         prod_im = 24'hC2F700;
         cur_strobe = 1'b1;
         cyc();
         cur_strobe = 1'b0;
         repeat (20) cyc();
         upd(1'b1);
      end
      note("current");
      slow_link = 1'b1;
      n = 0;
      repeat (6) begin
         cycle_tick = 1'b1;
         cyc();
         cycle_tick = 1'b0;
         n += loop_upd;
         cyc();
      end
      chk(n, 2);
      slow_link = 1'b0;
      note("slow link");
      for (i = 0; i < 6; i++) begin
         ofs = 8'($random(seed));
         dly = 8'h03 + 8'($random(seed) & 63);
         send(1'b0);
         await_reply();
         upd(1'b0);
      end
      note("random exchange");
      send_su = 1'b1;
      send(1'b0);
      await_reply();
      upd(1'b0);
      send_su = 1'b0;
      send(1'b0);
      await_reply();
      repeat (250) cyc();
      send(1'b1);
      await_reply();
      note("start-up");
      conclude();
   end
endmodule
`default_nettype wire
